// ===== rtl/acsreg_bank.v
/*
  Access-control capability register bank behind an APB slave.
  Assumes a single 20 MHz core clock and APB master on that clock;
  capability strap inputs are static after reset.
*/
// Operation
// - Structure present only in root, switch downstream port or multi-function function
// - Bridge and event collector never expose the structure
// - Switch upstream port exposes it only as a multi-function function
// - Header at 00h, capability at 04h, control in upper half
// - Egress vector follows at 08h, spanning more words if needed
// - Translation blocking bit read-only, forced zero outside root or downstream
// - Request redirect bit read-only, allowed only for qualifying port types
// - Completion redirect reads one exactly when request redirect does
// - Upstream forwarding bit read-only, downstream or qualifying root only
// - Direct translated bit read-only, downstream or qualifying root only
// - Bits 15:8 hold vector size, 00h means 256
// - Without egress control the vector is absent and reads zero
// - Capability bit 7 reserved, reads fixed value
// - Control at 06h, one read-write enable per service bits 0-6
// - Enables reset to zero, hardwired zero when service absent
// - Vector at 08h is read-write with size-field number of bits
`timescale 1ns/1ns
`default_nettype none
`include "acsreg_consts.vh"

module acsreg_bank #(
  parameter [2:0] PORT_TYPE = `ACSREG_PT_SWDN, // Kind of port or function
  parameter [6:0] SVC_IMPL = 7'h7F, // Services the logic implements
  parameter [7:0] VEC_SIZE = 8'h00, // Vector size field value
  parameter [31:0] HDR_VALUE = 32'h00000000, // Arbitrary header value
  parameter P2P_ROOT = 1, // Root port does peer traffic
  parameter P2P_FUNC = 1, // Function does peer traffic with siblings
  parameter RR_VALID = 1, // Root complex validates redirects
  parameter ATS_SUP = 1 // Root port supports translation services
) (
  input wire clk, // Core clock
  input wire rst, // Async reset, active high
  input wire mf_func, // Port is a multi-function function
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg present, // Structure exposed
  output reg [6:0] svc_en, // Active service enables
  output reg [255:0] egress_vec // Egress control bits
);

  localparam NWORDS = 8;
  localparam [8:0] NBITS = (VEC_SIZE == 8'h00) ? `ACSREG_SIZE_FULL : {1'b0, VEC_SIZE};

  wire is_root = (PORT_TYPE == `ACSREG_PT_ROOT);
  wire is_dn = (PORT_TYPE == `ACSREG_PT_SWDN);
  wire is_mfd = (PORT_TYPE == `ACSREG_PT_MFD) || mf_func;
  // Bridges and event collectors never qualify even inside a multi-function part
  wire banned = (PORT_TYPE == `ACSREG_PT_BRIDGE) || (PORT_TYPE == `ACSREG_PT_EVCOL);
  wire up_ok = (PORT_TYPE == `ACSREG_PT_SWUP) && mf_func;
  wire pres_d = !banned && (is_root || is_dn || is_mfd || up_ok);

  reg [6:0] allow;
  always @* begin
    allow = 7'h00;
    allow[`ACSREG_BIT_SRCVAL] = is_root || is_dn;
    allow[`ACSREG_BIT_XLBLK] = is_root || is_dn;
    allow[`ACSREG_BIT_REQRD] = is_dn || (is_root && P2P_ROOT != 0) ||
      (is_mfd && P2P_FUNC != 0);
    allow[`ACSREG_BIT_UPFWD] = is_dn || (is_root && RR_VALID != 0);
    allow[`ACSREG_BIT_EGRESS] = is_root || is_dn || is_mfd;
    allow[`ACSREG_BIT_DXLP2P] = is_dn || (is_root && ATS_SUP != 0 && P2P_ROOT != 0);
  end

  reg [6:0] cap;
  always @* begin
    cap = allow & SVC_IMPL & {7{pres_d}};
    // Mandatory services are advertised whatever SVC_IMPL says
    cap[`ACSREG_BIT_SRCVAL] = allow[`ACSREG_BIT_SRCVAL] & pres_d;
    cap[`ACSREG_BIT_XLBLK] = allow[`ACSREG_BIT_XLBLK] & pres_d;
    cap[`ACSREG_BIT_REQRD] = allow[`ACSREG_BIT_REQRD] & pres_d;
    cap[`ACSREG_BIT_CPLRD] = cap[`ACSREG_BIT_REQRD];
    cap[`ACSREG_BIT_UPFWD] = allow[`ACSREG_BIT_UPFWD] & pres_d;
    cap[`ACSREG_BIT_DXLP2P] = allow[`ACSREG_BIT_DXLP2P] & pres_d;
  end

  // Hardwired capability word; no storage, so writes cannot alter it
  wire [15:0] cap_word = {VEC_SIZE, `ACSREG_RSVD_VAL, cap};
  wire egress_on = cap[`ACSREG_BIT_EGRESS];

  reg [6:0] ctl_q;
  wire [255:0] vec_q;
  reg [255:0] vec_mask;
  integer k;
  always @* begin
    for (k = 0; k < 256; k = k + 1) begin
      vec_mask[k] = egress_on && (k < NBITS);
    end
  end

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire word_ok = (paddr[1:0] == 2'b00);
  wire hit_cap = word_ok && (paddr == `ACSREG_OFF_CAP);
  wire hit_hdr = word_ok && (paddr == `ACSREG_OFF_HDR);
  wire in_vec = word_ok && (paddr >= `ACSREG_OFF_VEC) &&
    (paddr < `ACSREG_OFF_VEC + 12'h020);
  wire [2:0] widx = paddr[4:2] - 3'h2;

  // Upper half of the offset-04h word carries the enables
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= `ACSREG_CTL_RST;
    end else if (wr && hit_cap && pres_d) begin
      if (pstrb[2]) begin
        ctl_q <= pwdata[`ACSREG_CTL_LSB +: `ACSREG_NSVC] & cap;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NWORDS; g = g + 1) begin : g_vec
      // Own word per entry keeps each storage bit to a single process
      reg [31:0] word_q;
      assign vec_q[g*32 +: 32] = word_q;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          word_q <= `ACSREG_VEC_RST;
        end else if (wr && in_vec && pres_d && widx == g) begin
          word_q[7:0] <= pstrb[0] ? pwdata[7:0] : word_q[7:0];
          word_q[15:8] <= pstrb[1] ? pwdata[15:8] : word_q[15:8];
          word_q[23:16] <= pstrb[2] ? pwdata[23:16] : word_q[23:16];
          word_q[31:24] <= pstrb[3] ? pwdata[31:24] : word_q[31:24];
        end
      end
    end
  endgenerate

  wire [255:0] vec_vis = vec_q & vec_mask;
  reg [31:0] rd_d;
  reg err_d;
  always @* begin
    rd_d = `ACSREG_RD_ZERO;
    err_d = 1'b0;
    if (!pres_d) begin
      err_d = 1'b1;
    end else if (hit_hdr) begin
      rd_d = HDR_VALUE;
    end else if (hit_cap) begin
      rd_d = {9'h000, ctl_q & cap, cap_word};
    end else if (in_vec) begin
      rd_d = vec_vis[widx*32 +: 32];
    end else begin
      err_d = 1'b1;
    end
  end

  // One wait state: ready in the cycle after the access phase opens
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= `ACSREG_RD_ZERO;
      pslverr <= 1'b0;
      present <= 1'b0;
      svc_en <= `ACSREG_CTL_RST;
      egress_vec <= 256'h0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_d : `ACSREG_RD_ZERO;
      pslverr <= acc && !pready && err_d;
      present <= pres_d;
      svc_en <= ctl_q & cap;
      egress_vec <= vec_vis;
    end
  end

endmodule // acsreg_bank

`default_nettype wire

// ===== rtl/acsreg_consts.vh
/*
  Offsets, field positions, reset values and encodings of the
  access-control capability register bank.
  Assumes inclusion by bare name from the bank's design file.
*/
`ifndef ACSREG_CONSTS_VH
`define ACSREG_CONSTS_VH

// Byte offsets within the structure
`define ACSREG_OFF_HDR 12'h000
`define ACSREG_OFF_CAP 12'h004
`define ACSREG_OFF_VEC 12'h008

// Control register occupies the upper half of the offset-04h word
`define ACSREG_CTL_LSB 16
`define ACSREG_NSVC 7

// Capability field positions
`define ACSREG_BIT_SRCVAL 0
`define ACSREG_BIT_XLBLK 1
`define ACSREG_BIT_REQRD 2
`define ACSREG_BIT_CPLRD 3
`define ACSREG_BIT_UPFWD 4
`define ACSREG_BIT_EGRESS 5
`define ACSREG_BIT_DXLP2P 6
`define ACSREG_BIT_RSVD 7
`define ACSREG_SIZE_LSB 8
`define ACSREG_SIZE_MSB 15

// Reserved-preserved capability bit reads this value
`define ACSREG_RSVD_VAL 1'b0

// Size encoding 00h means the full vector length
`define ACSREG_SIZE_FULL 9'h100

// Port type encodings
`define ACSREG_PT_ROOT 3'h0
`define ACSREG_PT_SWDN 3'h1
`define ACSREG_PT_SWUP 3'h2
`define ACSREG_PT_MFD 3'h3
`define ACSREG_PT_BRIDGE 3'h4
`define ACSREG_PT_EVCOL 3'h5
`define ACSREG_PT_OTHER 3'h6

`define ACSREG_CTL_RST 7'h00
`define ACSREG_VEC_RST 32'h00000000
`define ACSREG_RD_ZERO 32'h00000000

`endif

// ===== verif/acsreg_bank_asserts.sv
/* Checker for the access-control capability bank.
   Sees only the bank's ports; attached by the bind at the foot. */
`timescale 1ns/1ns
`default_nettype none
module acsreg_bank_asserts #(
  parameter [7:0] VEC_SIZE = 8'h00
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [6:0] svc_en, // Active enables
  input wire logic [255:0] egress_vec // Egress bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cap_rd;
    pready && !pwrite && !pslverr && paddr == 12'h004;
  endsequence
  sequence s_ctl_wr;
    pready && pwrite && !pslverr && paddr == 12'h004 && pstrb[2];
  endsequence
  AST_READY_LAT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_SIZE_FIELD: assert property (s_cap_rd |-> prdata[15:8] == VEC_SIZE)
    else $error("size field wrong");
  AST_RSVD_BIT: assert property (s_cap_rd |-> !prdata[7] && prdata[3] == prdata[2])
    else $error("reserved or redirect bit wrong");
  AST_CTL_READBACK: assert property (s_cap_rd |-> prdata[22:16] == svc_en)
    else $error("control readback wrong");
  AST_CTL_HARDWIRE: assert property (s_cap_rd |-> (prdata[22:16] & ~prdata[6:0]) == 7'h00)
    else $error("enable set without service");
  AST_CTL_WRITE: assert property (s_ctl_wr |=> (svc_en & ~$past(pwdata[22:16])) == 7'h00)
    else $error("enable set without write");
  AST_CTL_HOLD: assert property ($changed(svc_en) |-> $past(pready && pwrite))
    else $error("enables moved without write");
  AST_CTL_RST: assert property ($past(rst) |-> svc_en == 7'h00 && egress_vec == 256'h0)
    else $error("enables not cleared by reset");
  AST_ERR_RDZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_VEC_RANGE: assert property (VEC_SIZE == 8'h00 || (egress_vec >> VEC_SIZE) == 256'h0)
    else $error("vector bit beyond size");
endmodule // acsreg_bank_asserts
bind acsreg_bank acsreg_bank_asserts #(.VEC_SIZE(VEC_SIZE)) acsreg_bank_asserts_inst (.clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .svc_en,
  .egress_vec);
`default_nettype wire

// ===== verif/acsreg_bank_tb.sv
/* Self-checking bench for the capability bank, switch downstream port.
   Drives APB itself; checker attached by bind. */
`timescale 1ns/1ns
`default_nettype none
module acsreg_bank_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, present, e;
  logic mf = 1'b0, up_pready, up_pslverr, up_present, br_present, ue;
  logic [31:0] up_prdata, uq;
  logic [6:0] svc_en;
  logic [255:0] egress_vec;
  int err_count = 0, samples_checked = 0;
  always #25 clk = ~clk;
  // Short vector so the size cut-off lands inside word 1
  acsreg_bank #(.VEC_SIZE(8'h28)) acsreg_bank_inst (.clk, .rst, .mf_func(1'b0), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .present,
    .svc_en, .egress_vec);
  // Upstream port qualifies only as a multi-function function
  acsreg_bank #(.PORT_TYPE(3'h2)) acsreg_bank_up_inst (.clk, .rst, .mf_func(mf), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(up_prdata), .pready(up_pready),
    .pslverr(up_pslverr), .present(up_present), .svc_en(), .egress_vec());
  // Bridge stays absent even with the multi-function strap high
  acsreg_bank #(.PORT_TYPE(3'h4)) acsreg_bank_br_inst (.clk, .rst, .mf_func(mf), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(),
    .present(br_present), .svc_en(), .egress_vec());
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while ((pready !== 1'b1 || up_pready !== 1'b1) && n < 20);
    if (pready !== 1'b1 || up_pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    uq = up_prdata;
    ue = up_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(nm, x, q);
    chk(nm, {31'h0, xe}, {31'h0, e});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc("cap", 12'h004, 32'h0000287F, 1'b0);
    chk("present", 32'h1, {31'h0, present});
    chk("up_rd", 32'h0, uq);
    chk("up_err", 32'h1, {31'h0, ue});
    chk("up_present", 32'h0, {31'h0, up_present});
    chk("br_present", 32'h0, {31'h0, br_present});
    apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF);
    rdc("hdr", 12'h000, 32'h0, 1'b0);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
    rdc("cap_ctl", 12'h004, 32'h007F287F, 1'b0);
    chk("svc_en", 32'h7F, {25'h0, svc_en});
    apb(1'b1, 12'h004, 32'h0, 4'h3);
    rdc("cap_lo", 12'h004, 32'h007F287F, 1'b0);
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    rdc("ctl_clr", 12'h004, 32'h0000287F, 1'b0);
    apb(1'b1, 12'h008, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, 12'h024, 32'hFFFFFFFF, 4'hF);
    rdc("vec0", 12'h008, 32'hFFFFFFFF, 1'b0);
    rdc("vec1", 12'h00C, 32'h000000FF, 1'b0);
    rdc("vec7", 12'h024, 32'h0, 1'b0);
    chk("egress", 32'hFF, egress_vec[63:32]);
    rdc("unmapped", 12'h028, 32'h0, 1'b1);
    rdc("unaligned", 12'h005, 32'h0, 1'b1);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
    // Mid-run reset; the strap only moves while reset holds
    @(posedge clk);
    rst <= 1'b1;
    mf <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc("ctl_rst", 12'h004, 32'h0000287F, 1'b0);
    chk("svc_rst", 32'h0, {25'h0, svc_en});
    chk("up_cap", 32'h0000002C, uq);
    chk("up_ok", 32'h0, {31'h0, ue});
    chk("up_on", 32'h1, {31'h0, up_present});
    chk("br_mf", 32'h0, {31'h0, br_present});
    wrap_up();
  end
endmodule // acsreg_bank_tb
`default_nettype wire
